/* File: rtl/write_once_option_registers.sv */
// Purpose: two write-once option registers and the logic they steer
// Assumes: crystal and bus ticks are enables on i_clk_sys; supply
//   comparator levels arrive asynchronously from the analog monitor
// Notes: the emulator bit and the monitor reset state are cleared only
//   by power-on reset so that a monitor reset cannot clear itself
// What this block does
// - each option register reads its default after reset (the emulator bit only after power-on reset), takes one write, then ignores writes until reset.
// - with the monitor and its reset enabled, reset asserts after nine consecutive low-supply cycles and holds until the supply rises again.
// - the monitor stays on in stop mode only when both its power and stop-enable bits are one.
// - the monitor reset-enable bit lets the monitor drive a system reset, and zero blocks it.
// - the monitor power bit powers the monitor when one and powers it down when zero.
// - stop exit waits 32 crystal cycles with short recovery set, otherwise 4096.
// - watchdog timeout is 2^13-2^4 crystal cycles with the select bit one, else 2^18-2^4.
// - the stop instruction runs when stop-enable is one and is an illegal opcode when zero.
// - the watchdog-disable bit turns the watchdog off when one.
// - a read-only revision bit marks newer silicon and ignores writes.
// - the eeprom timebase dividers use the bus clock when the select bit is one, else the crystal clock.
// - the can-disable bit turns the can controller off when one.
// - the emulator bit picks the first personality when one, the second when zero, and reads zero after power-on reset.
// - only power-on reset clears the emulator bit.
`timescale 1ns/1ps
module write_once_option_registers #(
  parameter logic REVISION = 1'b1, // arbitrary value
  parameter logic [17:0] WDT_SHORT = 18'(option_regs_pkg::WDT_SHORT_XTAL),
  parameter logic [17:0] WDT_LONG = 18'(option_regs_pkg::WDT_LONG_XTAL)
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_por,
  input wire logic [option_regs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [option_regs_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [option_regs_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_crystal_tick,
  input wire logic i_supply_below_fall,
  input wire logic i_supply_above_rise,
  input wire logic i_stop_mode,
  input wire logic i_stop_instr,
  input wire logic i_stop_wake,
  input wire logic i_watchdog_service,
  output logic o_monitor_active,
  output logic o_monitor_reset,
  output logic o_stop_enter,
  output logic o_stop_illegal,
  output logic o_stop_release,
  output logic o_watchdog_reset,
  output logic o_watchdog_enabled,
  output logic o_eeprom_divider_tick,
  output logic o_can_disable,
  output logic o_emulator_select
);
  import option_regs_pkg::*;

  // option registers and their write locks
  opt_a_t opt_a_reg, opt_a_next;
  opt_b_t opt_b_reg, opt_b_next;
  logic lock_a_reg, lock_a_next, lock_b_reg, lock_b_next;
  logic emu_reg, emu_next;
  logic [7:0] rd_reg, rd_next;
  logic wr_a, wr_b;

  assign wr_a = i_wr_stb && (i_addr == OPT_A_IDX);
  assign wr_b = i_wr_stb && (i_addr == OPT_B_IDX);

  always_comb begin
    opt_a_next = opt_a_reg;
    opt_b_next = opt_b_reg;
    lock_a_next = lock_a_reg;
    lock_b_next = lock_b_reg;
    emu_next = emu_reg;
    if (wr_a && !lock_a_reg) begin
      opt_a_next = opt_a_t'(i_wr_data);
      lock_a_next = 1'b1;
    end
    if (wr_b && !lock_b_reg) begin
      opt_b_next = opt_b_t'(i_wr_data);
      emu_next = i_wr_data[0];
      lock_b_next = 1'b1;
    end
    opt_b_next.revision_indicator = REVISION;
    opt_b_next.spare = 4'h0;
    opt_a_next.spare = 1'b0;
    rd_next = 8'h00;
    if (i_rd_stb) begin
      case (i_addr)
        OPT_A_IDX: rd_next = opt_a_reg;
        OPT_B_IDX: rd_next = {opt_b_reg[7:1], emu_reg};
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_por) begin
      opt_a_reg <= opt_a_t'(OPT_A_RESET);
      opt_b_reg <= opt_b_t'(OPT_B_RESET);
      opt_b_reg.revision_indicator <= REVISION;
      lock_a_reg <= 1'b0;
      lock_b_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      opt_a_reg <= opt_a_next;
      opt_b_reg <= opt_b_next;
      lock_a_reg <= lock_a_next;
      lock_b_reg <= lock_b_next;
      rd_reg <= rd_next;
    end
  end

  // emulator bit survives every reset but power-on
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      emu_reg <= 1'b0;
    end else if (i_srst) begin
      emu_reg <= emu_reg;
    end else begin
      emu_reg <= emu_next;
    end
  end

  assign o_rd_data = rd_reg;

  // supply comparator synchronisers
  logic [1:0] below_sync_reg, above_sync_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      below_sync_reg <= 2'b00;
      above_sync_reg <= 2'b00;
    end else begin
      below_sync_reg <= {below_sync_reg[0], i_supply_below_fall};
      above_sync_reg <= {above_sync_reg[0], i_supply_above_rise};
    end
  end

  // low-voltage monitor
  logic mon_active;
  logic [3:0] low_cnt_reg, low_cnt_next;
  logic mon_rst_reg, mon_rst_next;
  assign mon_active = opt_a_reg.monitor_power_enable &&
    (!i_stop_mode || opt_a_reg.monitor_stop_enable);

  always_comb begin
    low_cnt_next = 4'h0;
    if (mon_active && below_sync_reg[1]) begin
      low_cnt_next = (low_cnt_reg == LOW_SUPPLY_CYCLES) ?
        low_cnt_reg : low_cnt_reg + 4'h1;
    end
    mon_rst_next = mon_rst_reg;
    if (mon_rst_reg && above_sync_reg[1]) begin
      mon_rst_next = 1'b0;
    end else if (low_cnt_reg == LOW_SUPPLY_CYCLES &&
        opt_a_reg.monitor_reset_enable) begin
      mon_rst_next = 1'b1;
    end
  end

  // cleared by power-on only: the monitor reset feeds the system reset
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      low_cnt_reg <= 4'h0;
      mon_rst_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      mon_rst_reg <= mon_rst_next;
    end
  end

  assign o_monitor_active = mon_active;
  assign o_monitor_reset = mon_rst_reg;

  // checking aid: run of cycles in which the monitor must count toward
  // a reset; saturates one past the trip count so the check stays armed
  logic [3:0] low_run_reg, low_run_next;
  always_comb begin
    low_run_next = 4'h0;
    if (mon_active && below_sync_reg[1] && !above_sync_reg[1] &&
        opt_a_reg.monitor_reset_enable) begin
      low_run_next = (low_run_reg == LOW_SUPPLY_CYCLES + 4'h1) ?
        low_run_reg : low_run_reg + 4'h1;
    end
  end

  // follows the monitor state, so only power-on clears it
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      low_run_reg <= 4'h0;
    end else begin
      low_run_reg <= low_run_next;
    end
  end

  // stop entry and recovery delay
  rec_state_t rec_reg, rec_next;
  logic [12:0] rec_cnt_reg, rec_cnt_next;
  assign o_stop_enter = i_stop_instr && opt_a_reg.stop_enable;
  assign o_stop_illegal = i_stop_instr && !opt_a_reg.stop_enable;

  always_comb begin
    rec_next = rec_reg;
    rec_cnt_next = rec_cnt_reg;
    case (rec_reg)
      REC_IDLE: begin
        if (i_stop_wake) begin
          rec_next = REC_COUNT;
          rec_cnt_next = opt_a_reg.short_recovery_select ?
            STOP_SHORT_CNT : STOP_LONG_CNT;
        end
      end
      REC_COUNT: begin
        if (i_crystal_tick) begin
          rec_cnt_next = rec_cnt_reg - 13'h1;
          if (rec_cnt_reg == 13'h1) begin
            rec_next = REC_DONE;
          end
        end
      end
      REC_DONE: rec_next = REC_IDLE;
      default: rec_next = REC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_por) begin
      rec_reg <= REC_IDLE;
      rec_cnt_reg <= 13'h0;
    end else begin
      rec_reg <= rec_next;
      rec_cnt_reg <= rec_cnt_next;
    end
  end

  assign o_stop_release = (rec_reg == REC_DONE);

  // watchdog timebase
  logic [17:0] wdt_cnt_reg, wdt_cnt_next, wdt_limit;
  logic wdt_fire;
  assign wdt_limit = opt_a_reg.watchdog_timeout_select ?
    WDT_SHORT : WDT_LONG;
  assign wdt_fire = !opt_a_reg.watchdog_disable && i_crystal_tick &&
    (wdt_cnt_reg == wdt_limit - 18'h1);

  always_comb begin
    wdt_cnt_next = wdt_cnt_reg;
    if (opt_a_reg.watchdog_disable || i_watchdog_service || wdt_fire) begin
      wdt_cnt_next = 18'h0;
    end else if (i_crystal_tick) begin
      wdt_cnt_next = wdt_cnt_reg + 18'h1;
    end
  end

  logic wdt_rst_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_por) begin
      wdt_cnt_reg <= 18'h0;
      wdt_rst_reg <= 1'b0;
    end else begin
      wdt_cnt_reg <= wdt_cnt_next;
      wdt_rst_reg <= wdt_fire;
    end
  end

  assign o_watchdog_reset = wdt_rst_reg;
  assign o_watchdog_enabled = !opt_a_reg.watchdog_disable;
  // bus clock is i_clk_sys itself, so its tick is every cycle
  assign o_eeprom_divider_tick = opt_b_reg.eeprom_divider_clock_select ?
    1'b1 : i_crystal_tick;
  assign o_can_disable = opt_b_reg.can_disable;
  assign o_emulator_select = emu_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst || i_por);

  chk_lock_holds_a: assert property (
    lock_a_reg && wr_a |=> $stable(opt_a_reg))
    else $error("option a changed after lock");
  chk_first_write_b: assert property (
    !lock_b_reg && wr_b |=> lock_b_reg &&
      opt_b_reg.can_disable == $past(i_wr_data[5]))
    else $error("first write to option b not taken");
  chk_rev_readonly: assert property (
    opt_b_reg.revision_indicator == REVISION)
    else $error("revision bit moved");
  chk_low_nine: assert property (
    low_run_reg == LOW_SUPPLY_CYCLES + 4'h1 |-> mon_rst_reg)
    else $error("monitor reset missing after low supply");
  chk_monitor_gate: assert property (
    !mon_rst_reg && !opt_a_reg.monitor_reset_enable |=> !mon_rst_reg)
    else $error("monitor reset without enable");
  chk_stop_active: assert property (
    i_stop_mode && !opt_a_reg.monitor_stop_enable |-> !o_monitor_active)
    else $error("monitor on in stop mode");
  chk_stop_decode: assert property (
    i_stop_instr |-> (o_stop_illegal != opt_a_reg.stop_enable))
    else $error("stop instruction decode wrong");
  chk_short_recovery: assert property (
    rec_reg == REC_IDLE && i_stop_wake && opt_a_reg.short_recovery_select
      |=> rec_cnt_reg == STOP_SHORT_CNT)
    else $error("short recovery count wrong");
  chk_wdt_off: assert property (
    opt_a_reg.watchdog_disable |=> !o_watchdog_reset)
    else $error("watchdog fired while disabled");
  chk_emu_keeps: assert property (@(posedge i_clk_sys) disable iff (i_por)
    i_srst |=> $stable(emu_reg))
    else $error("emulator bit lost on system reset");

  cov_lock_a: cover property (!lock_a_reg && wr_a ##1 wr_a);
  cov_monitor_reset: cover property ($rose(mon_rst_reg));
  cov_stop_release: cover property (rec_reg == REC_DONE);
  cov_wdt_fire: cover property (wdt_fire);
endmodule

/* File: rtl/option_regs_pkg.sv */
// Purpose: shared constants and types for the write-once option registers
// Assumes: 8-bit register port, one register per index
// Notes: field order of the structs is the bit layout, msb first
package option_regs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OPT_A_IDX = 4'h0;
  localparam logic [3:0] OPT_B_IDX = 4'h1;
  localparam logic [7:0] OPT_A_RESET = 8'h60;
  localparam logic [7:0] OPT_B_RESET = 8'h00;
  // revision indicator position in option register b
  localparam int REV_BIT = 7;
  // consecutive bus cycles of low supply before a monitor reset
  localparam logic [3:0] LOW_SUPPLY_CYCLES = 4'h9;
  // stop recovery delays in crystal clock cycles
  localparam int STOP_SHORT_XTAL = 32;
  localparam int STOP_LONG_XTAL = 4096;
  localparam logic [12:0] STOP_SHORT_CNT = 13'(STOP_SHORT_XTAL);
  localparam logic [12:0] STOP_LONG_CNT = 13'(STOP_LONG_XTAL);
  // watchdog timeouts in crystal clock cycles
  localparam int WDT_SHORT_XTAL = (1 << 13) - (1 << 4);
  localparam int WDT_LONG_XTAL = (1 << 18) - (1 << 4);

  typedef struct packed {
    logic monitor_stop_enable;
    logic monitor_reset_enable;
    logic monitor_power_enable;
    logic short_recovery_select;
    logic watchdog_timeout_select;
    logic stop_enable;
    logic watchdog_disable;
    logic spare;
  } opt_a_t;

  typedef struct packed {
    logic revision_indicator;
    logic eeprom_divider_clock_select;
    logic can_disable;
    logic [3:0] spare;
    logic emulator_select;
  } opt_b_t;

  typedef enum logic [1:0] {
    REC_IDLE = 2'b00,
    REC_COUNT = 2'b01,
    REC_DONE = 2'b11
  } rec_state_t;
endpackage

/* File: verification/write_once_option_registers_test.sv */
// Purpose: self-checking bench for the write-once option registers
// Assumes: WDT limits shortened to 20/40 ticks, revision parameter 1
// Notes: crystal ticks come every other cycle so that pulse timing is loose
`timescale 1ns/1ps
module write_once_option_registers_test;
  import option_regs_pkg::*;
  logic i_clk_sys, i_srst, i_por, i_wr_stb, i_rd_stb, i_crystal_tick;
  logic [3:0] i_addr;
  logic [7:0] i_wr_data, o_rd_data, v, da, db;
  logic i_supply_below_fall, i_supply_above_rise, i_stop_mode, i_stop_instr;
  logic i_stop_wake, i_watchdog_service, o_monitor_active, o_monitor_reset;
  logic o_stop_enter, o_stop_illegal, o_stop_release, o_watchdog_reset;
  logic o_watchdog_enabled, o_eeprom_divider_tick, o_can_disable;
  logic o_emulator_select;
  int seed, failures, comparisons, n;
  wire [2:0] stop_view = {o_monitor_active, o_stop_enter, o_stop_illegal};

  write_once_option_registers #(.REVISION(1'b1), .WDT_SHORT(18'h14),
    .WDT_LONG(18'h28)) dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_por(i_por), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .i_crystal_tick(i_crystal_tick), .i_supply_below_fall(i_supply_below_fall),
    .i_supply_above_rise(i_supply_above_rise), .i_stop_mode(i_stop_mode),
    .i_stop_instr(i_stop_instr), .i_stop_wake(i_stop_wake),
    .i_watchdog_service(i_watchdog_service),
    .o_monitor_active(o_monitor_active), .o_monitor_reset(o_monitor_reset),
    .o_stop_enter(o_stop_enter), .o_stop_illegal(o_stop_illegal),
    .o_stop_release(o_stop_release), .o_watchdog_reset(o_watchdog_reset),
    .o_watchdog_enabled(o_watchdog_enabled),
    .o_eeprom_divider_tick(o_eeprom_divider_tick),
    .o_can_disable(o_can_disable), .o_emulator_select(o_emulator_select));

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // spare bit 0 reads zero
  function automatic logic [7:0] exp_a(input logic [7:0] d);
    return d & 8'hfe;
  endfunction
  // revision reads 1 whatever is written, spares read zero
  function automatic logic [7:0] exp_b(input logic [7:0] d);
    return {1'b1, d[6:5], 4'h0, d[0]};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr_stb <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk_sys);
    i_wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd_stb <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_stb <= 1'b0;
    #1 d = o_rd_data;
  endtask

  task automatic pulse_rst(input logic por);
    @(posedge i_clk_sys);
    if (por) i_por <= 1'b1;
    else i_srst <= 1'b1;
    @(posedge i_clk_sys);
    i_por <= 1'b0;
    i_srst <= 1'b0;
  endtask

  // ticks every other cycle until the chosen pulse is seen
  task automatic count_ticks(input logic wdt, output int cnt);
    logic seen;
    seen = 1'b0;
    cnt = 0;
    while (!seen && cnt < 5000) begin
      @(posedge i_clk_sys);
      i_crystal_tick <= 1'b1;
      #1 seen = wdt ? o_watchdog_reset : o_stop_release;
      if (!seen) begin
        @(posedge i_clk_sys);
        i_crystal_tick <= 1'b0;
        cnt++;
        #1 seen = wdt ? o_watchdog_reset : o_stop_release;
      end
    end
    i_crystal_tick <= 1'b0;
  endtask

  task automatic pulse(input int which);
    @(posedge i_clk_sys);
    if (which == 0) i_stop_wake <= 1'b1;
    else i_watchdog_service <= 1'b1;
    @(posedge i_clk_sys);
    i_stop_wake <= 1'b0;
    i_watchdog_service <= 1'b0;
  endtask

  // recovery and watchdog lengths, then monitor reset behaviour
  task automatic timing(input int rec, input int wdt, input logic mon);
    pulse(0);
    count_ticks(1'b0, n);
    check(n, rec);
    pulse(1);
    count_ticks(1'b1, n);
    check(n, wdt);
    @(posedge i_clk_sys);
    i_supply_below_fall <= 1'b1;
    // two sync edges, nine counting edges, then the reset edge
    repeat (11) @(posedge i_clk_sys);
    #1 check(o_monitor_reset, 8'h0);
    @(posedge i_clk_sys);
    #1 check(o_monitor_reset, mon);
    i_supply_below_fall <= 1'b0;
    i_supply_above_rise <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1 check(o_monitor_reset, 8'h0);
    i_supply_above_rise <= 1'b0;
  endtask

  initial begin
    #800000;
    failures++;
    report_and_stop();
  end

  initial begin
    seed = 89;
    failures = 0;
    comparisons = 0;
    {i_srst, i_por} = 2'b11;
    {i_wr_stb, i_rd_stb, i_crystal_tick, i_stop_mode, i_stop_instr} = '0;
    {i_supply_below_fall, i_supply_above_rise, i_stop_wake} = '0;
    i_watchdog_service = 1'b0;
    i_addr = '0;
    i_wr_data = '0;
    repeat (16) @(posedge i_clk_sys);
    {i_srst, i_por} <= 2'b00;
    rd(OPT_A_IDX, v); check(v, OPT_A_RESET);
    rd(OPT_B_IDX, v); check(v, 8'h80);
    #1 @(posedge i_clk_sys); #1 check(o_rd_data, 8'h0);
    da = 8'($random(seed));
    db = (8'($random(seed)) | 8'h01) & 8'h7f;
    wr(OPT_A_IDX, da);
    wr(OPT_A_IDX, ~da);
    wr(OPT_B_IDX, db);
    wr(OPT_B_IDX, ~db);
    wr(4'h5, 8'hff);
    rd(4'h5, v); check(v, 8'h0);
    rd(OPT_A_IDX, v); check(v, exp_a(da));
    rd(OPT_B_IDX, v); check(v, exp_b(db));
    check(o_watchdog_enabled, !da[1]);
    check(o_can_disable, db[5]);
    check(o_eeprom_divider_tick, db[6]);
    check(o_emulator_select, 8'h1);
    pulse_rst(1'b0);
    rd(OPT_B_IDX, v); check(v, 8'h81);
    pulse_rst(1'b1);
    rd(OPT_B_IDX, v); check(v, 8'h80);
    check(o_emulator_select, 8'h0);
    wr(OPT_A_IDX, 8'hfc);
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b1;
    i_stop_instr <= 1'b1;
    #1 check(stop_view, 8'h6);
    @(posedge i_clk_sys);
    {i_stop_mode, i_stop_instr} <= 2'b00;
    timing(STOP_SHORT_XTAL, 20, 1'b1);
    pulse_rst(1'b0);
    wr(OPT_A_IDX, 8'h20); // crystal run keeps short recovery clear
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b1;
    i_stop_instr <= 1'b1;
    #1 check(stop_view, 8'h1);
    @(posedge i_clk_sys);
    {i_stop_mode, i_stop_instr} <= 2'b00;
    #1 check(o_monitor_active, 8'h1);
    timing(STOP_LONG_XTAL, 40, 1'b0);
    pulse_rst(1'b0);
    wr(OPT_A_IDX, 8'h00);
    #1 check(o_monitor_active, 8'h0);
    // option b back at default: divider follows the crystal tick
    @(posedge i_clk_sys);
    i_crystal_tick <= 1'b1;
    #1 check(o_eeprom_divider_tick, 8'h1);
    report_and_stop();
  end
endmodule
